/* src/ccu_cfg.svh */
// Register map, field positions and reset values of the comparator control unit
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCU_ADDR_CTRL0 8'h9B
`define CCU_ADDR_CTRL1 8'h9D

// ----------------------------------------
// Field positions and reset value
// ----------------------------------------
`define CCU_BIT_EN 7
`define CCU_BIT_OUT 6
`define CCU_BIT_RISE 5
`define CCU_BIT_FALL 4
`define CCU_HYP_HI 3
`define CCU_HYP_LO 2
`define CCU_HYN_HI 1
`define CCU_HYN_LO 0
`define CCU_CTRL_RESET 8'h00

`endif

/* src/ccu_pkg.sv */
// Types shared by the comparator control unit
package ccu_pkg;
  // Settings driven into one analog comparator core
  typedef struct packed {
    logic enable;
    logic [1:0] positive_hysteresis_select;
    logic [1:0] negative_hysteresis_select;
  } ccu_analog_ctrl_t;

  // Register write strobe with data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccu_sfr_wr_t;
endpackage

/* src/ccu_comparator_control.sv */
// Control and status registers for two analog comparators
//
// Function
// - One independent control register per comparator, instances 0 and 1.
// - Hysteresis selection lives in control bits 3 to 0, positive and negative independent.
// - Positive field codes 00 off, 01 5mV, 10 10mV, 11 20mV.
// - Negative field bits 1-0 codes 00 off, 01 5mV, 10 10mV, 11 20mV.
// - Falling output transition sets falling-edge flag, bit 4.
// - Rising output transition sets rising-edge flag, bit 5.
// - Edge flags stay set until software writes zero; hardware never clears.
// - Edge flags drive comparator interrupt requests for rising and falling.
// - Bit 6 is read-only live comparator output.
// - Bit 7 enables comparator when one, disables when zero.
// - Enabled comparator with output zero requests oscillator wake from suspend.
// - Spurious flags on enable or setting change are not suppressed.
`timescale 1ns/1ps
`include "ccu_cfg.svh"

module ccu_comparator_control
  import ccu_pkg::*;
#(
  parameter int NUM_CMP = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ccu_sfr_wr_t sfr_wr,
  input wire logic [7:0] sfr_rd_addr,
  output logic [7:0] sfr_rdata,
  output logic sfr_rd_hit,
  input wire logic [NUM_CMP-1:0] cmp_out_raw,
  output ccu_analog_ctrl_t [NUM_CMP-1:0] analog_ctrl,
  output logic [NUM_CMP-1:0] rise_irq,
  output logic [NUM_CMP-1:0] fall_irq,
  output logic osc_wake_req
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Only two instances have documented addresses; extra ones decode at the CTRL1 address
  wire logic [NUM_CMP-1:0] wr_sel;
  wire logic [NUM_CMP-1:0] rd_sel;
  wire logic [7:0] ctrl_addr [NUM_CMP];
  // Reset image, sliced per field so every reset load keeps its width
  wire logic [7:0] rst_img;

  assign rst_img = `CCU_CTRL_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_dec
      assign ctrl_addr[gi] = (gi == 0) ? `CCU_ADDR_CTRL0 : `CCU_ADDR_CTRL1;
      assign wr_sel[gi] = sfr_wr.wr && (sfr_wr.addr == ctrl_addr[gi]);
      assign rd_sel[gi] = (sfr_rd_addr == ctrl_addr[gi]);
    end
  endgenerate

  // ----------------------------------------
  // Per-comparator registers
  // ----------------------------------------
  logic [7:0] ctrl_rd [NUM_CMP];
  logic [NUM_CMP-1:0] wake_each;

  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      logic en_q;
      logic en_d;
      logic [1:0] hyp_q;
      logic [1:0] hyp_d;
      logic [1:0] hyn_q;
      logic [1:0] hyn_d;
      logic rise_q;
      logic rise_d;
      logic fall_q;
      logic fall_d;
      logic sync1_q;
      logic sync2_q;
      logic prev_q;
      wire logic rise_ev;
      wire logic fall_ev;

      // Edge detect on synchronized output against the previous sample
      assign rise_ev = sync2_q && !prev_q;
      assign fall_ev = !sync2_q && prev_q;

      // Software writes; a same-cycle edge beats a clearing write
      assign en_d = wr_sel[gi] ? sfr_wr.wdata[`CCU_BIT_EN] : en_q;
      assign hyp_d = wr_sel[gi] ? sfr_wr.wdata[`CCU_HYP_HI:`CCU_HYP_LO] : hyp_q;
      assign hyn_d = wr_sel[gi] ? sfr_wr.wdata[`CCU_HYN_HI:`CCU_HYN_LO] : hyn_q;
      assign rise_d = rise_ev | (wr_sel[gi] ? sfr_wr.wdata[`CCU_BIT_RISE] : rise_q);
      assign fall_d = fall_ev | (wr_sel[gi] ? sfr_wr.wdata[`CCU_BIT_FALL] : fall_q);

      // Control state
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          en_q <= rst_img[`CCU_BIT_EN];
          hyp_q <= rst_img[`CCU_HYP_HI:`CCU_HYP_LO];
          hyn_q <= rst_img[`CCU_HYN_HI:`CCU_HYN_LO];
          rise_q <= rst_img[`CCU_BIT_RISE];
          fall_q <= rst_img[`CCU_BIT_FALL];
        end else begin
          en_q <= en_d;
          hyp_q <= hyp_d;
          hyn_q <= hyn_d;
          rise_q <= rise_d;
          fall_q <= fall_d;
        end
      end

      // Two-stage synchroniser plus history; edges while enabling are kept, not masked
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          sync1_q <= cmp_out_raw[gi];
          sync2_q <= sync1_q;
          prev_q <= sync2_q;
        end
      end

      // Readback image: enable, live output, flags, hysteresis codes
      assign ctrl_rd[gi] = {en_q, sync2_q, rise_q, fall_q, hyp_q, hyn_q};
      assign analog_ctrl[gi].enable = en_q;
      assign analog_ctrl[gi].positive_hysteresis_select = hyp_q;
      assign analog_ctrl[gi].negative_hysteresis_select = hyn_q;
      assign rise_irq[gi] = rise_q;
      assign fall_irq[gi] = fall_q;
      assign wake_each[gi] = en_q && !sync2_q;
    end
  endgenerate

  // ----------------------------------------
  // Read mux and wake request
  // ----------------------------------------
  // Unmapped addresses read zero and no hit
  always_comb begin
    sfr_rdata = 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (rd_sel[i]) begin
        sfr_rdata = ctrl_rd[i];
      end
    end
  end

  assign sfr_rd_hit = |rd_sel;
  assign osc_wake_req = |wake_each;

endmodule

/* sim/ccu_cmp_model.sv */
// Behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module ccu_cmp_model (
  input wire logic [1:0] en,
  input wire logic [1:0] lvl,
  output logic [1:0] cmp_out_raw
);
  // A core that is off reads low, so switching it on may look like an edge
  assign cmp_out_raw = en & lvl;
endmodule

/* sim/ccu_chk.sv */
// Assertions on the comparator control ports
`timescale 1ns/1ps
module ccu_chk
  import ccu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire ccu_sfr_wr_t sfr_wr,
  input wire logic [1:0] cmp_out_raw,
  input wire ccu_analog_ctrl_t [1:0] analog_ctrl,
  input wire logic [1:0] rise_irq,
  input wire logic [1:0] fall_irq,
  input wire logic osc_wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Flags lag the raw input by two sync stages and one edge stage
  wire logic r0 = cmp_out_raw[0];
  wire logic w0 = sfr_wr.wr && sfr_wr.addr == 8'h9B;
  a_rise_set: assert property ($rose(r0) ##1 $stable(r0)[*2] |=> rise_irq[0]) else $error("rise");
  a_fall_set: assert property ($fell(r0) ##1 $stable(r0)[*2] |=> fall_irq[0]) else $error("fall");
  a_rise_hold: assert property (rise_irq[0] && !w0 |=> rise_irq[0]) else $error("rise hold");
  a_fall_hold: assert property (fall_irq[0] && !w0 |=> fall_irq[0]) else $error("fall hold");
  a_wake_low: assert property ((analog_ctrl[0].enable && !r0)[*3] |-> osc_wake_req) else $error("wake");
  a_wake_off: assert property (!analog_ctrl[0].enable && !analog_ctrl[1].enable |-> !osc_wake_req)
    else $error("wake off");
  a_ctrl_write: assert property (w0 |=> analog_ctrl[0] == {$past(sfr_wr.wdata[7]), $past(sfr_wr.wdata[3:0])})
    else $error("ctrl");
  a_ctrl_indep: assert property (w0 |=> $stable(analog_ctrl[1])) else $error("indep");
endmodule
bind ccu_comparator_control ccu_chk i_ccu_chk (.ref_clk, .rst, .sfr_wr, .cmp_out_raw, .analog_ctrl, .rise_irq,
  .fall_irq, .osc_wake_req);

/* sim/tb_top.sv */
// Self-checking bench for the comparator control unit
`timescale 1ns/1ps
module tb_top;
  import ccu_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, osc_wake_req, sfr_rd_hit;
  logic [7:0] sfr_rd_addr = 8'h9B, sfr_rdata;
  logic [1:0] lvl = 2'h0, cmp_out_raw, rise_irq, fall_irq;
  ccu_sfr_wr_t sfr_wr = '0;
  ccu_analog_ctrl_t [1:0] analog_ctrl;
  int n_mismatch = 0, samples_checked = 0;
  ccu_comparator_control i_ccu_comparator_control (.ref_clk, .rst, .sfr_wr, .sfr_rd_addr, .sfr_rdata,
    .sfr_rd_hit, .cmp_out_raw, .analog_ctrl, .rise_irq, .fall_irq, .osc_wake_req);
  ccu_cmp_model i_ccu_cmp_model (.en({analog_ctrl[1].enable, analog_ctrl[0].enable}), .lvl, .cmp_out_raw);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Strobe raised at one edge, taken at the next; results read 1 ns later, once settled
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= {1'b1, a, d};
    @(posedge ref_clk);
    sfr_wr.wr <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Register access first, then output edges through the model
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    chk("reset", 8'h00, sfr_rdata);
    @(posedge ref_clk);
    rst <= 1'b0;
    wr(8'h9B, 8'hFF);
    chk("all", 8'hBF, sfr_rdata);
    wr(8'h9D, 8'h86);
    chk("ind", 8'h1F, {3'h0, analog_ctrl[0]});
    for (int i = 0; i < 16; i++) begin
      wr(8'h9B, 8'h80 + i[7:0]);
      chk("hys", 8'h10 + i[7:0], {3'h0, analog_ctrl[0]});
    end
    wr(8'h9D, 8'h00);
    chk("wake", 8'h01, {7'h0, osc_wake_req});
    $display("regs done");
    @(posedge ref_clk);
    lvl <= 2'h1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("rise", 8'hEF, sfr_rdata);
    chk("rise_irq", 8'h01, {7'h0, rise_irq[0]});
    @(posedge ref_clk);
    lvl <= 2'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("fall", 8'hBF, sfr_rdata);
    chk("fall_irq", 8'h01, {7'h0, fall_irq[0]});
    wr(8'h9B, 8'h00);
    chk("off", 8'h00, sfr_rdata | {7'h0, osc_wake_req});
    @(posedge ref_clk);
    sfr_rd_addr <= 8'h9D;
    #1;
    chk("cmp1", 8'h00, sfr_rdata);
    chk("hit", 8'h01, {7'h0, sfr_rd_hit});
    @(posedge ref_clk);
    sfr_rd_addr <= 8'h9C;
    #1;
    chk("miss", 8'h00, {sfr_rdata[7:1], sfr_rd_hit});
    $display("edges done");
    report_and_stop();
  end
endmodule
